// *** core/srg_status_pkg.sv ***
package srg_status_pkg;

    // Usable bits in every status register of a group.
    localparam int unsigned REG_W = 15;

    // Reset values of the group registers and of the host answer.
    localparam logic [14:0] COND_RST = 15'h0000;
    localparam logic [14:0] EVT_RST = 15'h0000;
    localparam logic [14:0] EN_RST = 15'h0000;
    localparam logic [14:0] DATA_RST = 15'h0000;

    // Host status commands, one per query or set operation.
    typedef enum logic [3:0] {
        SRG_CMD_NONE     = 4'h0,
        SRG_CMD_ALM_COND = 4'h1,
        SRG_CMD_ALM_EVT  = 4'h2,
        SRG_CMD_ALM_ENQ  = 4'h3,
        SRG_CMD_ALM_ENW  = 4'h4,
        SRG_CMD_OPR_COND = 4'h5,
        SRG_CMD_OPR_EVT  = 4'h6,
        SRG_CMD_OPR_ENQ  = 4'h7,
        SRG_CMD_OPR_ENW  = 4'h8,
        SRG_CMD_CLS      = 4'h9,
        SRG_CMD_PRESET   = 4'hA
    } srg_cmd_e_t;

    // One host request.
    typedef struct packed {
        logic valid;
        srg_cmd_e_t code;
        logic [14:0] data;
    } srg_cmd_t;

    // One answer to a query.
    typedef struct packed {
        logic valid;
        logic [14:0] data;
    } srg_resp_t;

    // The three registers of one status group.
    typedef struct packed {
        logic [14:0] cond;
        logic [14:0] evt;
        logic [14:0] en;
    } srg_grp_t;

    localparam srg_grp_t GRP_RST = '{cond: COND_RST, evt: EVT_RST,
                                     en: EN_RST};

endpackage

// *** core/srg_status_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Condition bits copy the instrument state every cycle, never latched.
// - Condition registers are read only; a query leaves them unchanged.
// - Event bits capture condition occurrences; the host cannot write them.
// - An already set event bit ignores further occurrences on that bit.
// - A set event bit stays until its group is read or clear status.
// - Enable bits mask which event bits reach the summary output.
// - Host writes any fifteen bit enable value and reads it back.
// - Condition query returns one unsigned fifteen bit value.
// - Alarm and operation groups each own condition, event, enable.
// - Status preset clears all enable registers, nothing else.
// - Power-on clear setting decides whether power up clears enables.
module srg_status_top (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Live instrument state for each group.
    input wire logic [14:0] alm_state_i,
    input wire logic [14:0] opr_state_i,
    // Power-on event and power-on status clear setting.
    input wire logic pwr_on_i,
    input wire logic psc_i,
    // Host command port.
    input wire srg_status_pkg::srg_cmd_t cmd_i,
    output srg_status_pkg::srg_resp_t resp_o,
    // Summary bits towards the status byte.
    output logic alm_summary_o,
    output logic opr_summary_o
);

    srg_status_pkg::srg_grp_t alm_q;
    srg_status_pkg::srg_grp_t alm_d;
    srg_status_pkg::srg_grp_t opr_q;
    srg_status_pkg::srg_grp_t opr_d;
    srg_status_pkg::srg_resp_t resp_q;
    srg_status_pkg::srg_resp_t resp_d;
    logic alm_sum_q;
    logic alm_sum_d;
    logic opr_sum_q;
    logic opr_sum_d;
    logic [14:0] alm_rise;
    logic [14:0] opr_rise;
    logic clr_en;
    logic cls;

    // Rising edges of the live state against the stored condition.
    function automatic logic [14:0] rise_of(input logic [14:0] state,
                                            input logic [14:0] cond);
        rise_of = state & ~cond;
    endfunction

    // Summary of one group: any enabled event bit.
    function automatic logic summary_of(input srg_status_pkg::srg_grp_t g);
        summary_of = |(g.evt & g.en);
    endfunction

    // Next state of one group; both groups share this so they stay alike.
    function automatic srg_status_pkg::srg_grp_t grp_next(
        input srg_status_pkg::srg_grp_t q,
        input logic [14:0] state,
        input logic evt_clr,
        input logic en_wr,
        input logic [14:0] en_data,
        input logic en_clr
    );
        srg_status_pkg::srg_grp_t n;
        n = q;
        n.cond = state;
        n.evt = (evt_clr ? srg_status_pkg::EVT_RST : q.evt)
                | rise_of(state, q.cond);
        if (en_clr) begin
            n.en = srg_status_pkg::EN_RST;
        end else if (en_wr) begin
            n.en = en_data;
        end
        grp_next = n;
    endfunction

    assign alm_rise = rise_of(alm_state_i, alm_q.cond);
    assign opr_rise = rise_of(opr_state_i, opr_q.cond);
    assign cls = cmd_i.valid && (cmd_i.code == srg_status_pkg::SRG_CMD_CLS);

    // Enables clear on preset, or on power up when the clear setting is on.
    // power-on clear choice
    assign clr_en = (cmd_i.valid
                     && (cmd_i.code == srg_status_pkg::SRG_CMD_PRESET))
                    || (pwr_on_i && psc_i);

    // Group registers: the host has no path into event or condition bits.
    // two independent groups
    // read or clear status empties events
    always_comb begin
        alm_d = grp_next(alm_q, alm_state_i,
            cls || (cmd_i.valid
                    && (cmd_i.code == srg_status_pkg::SRG_CMD_ALM_EVT)),
            cmd_i.valid && (cmd_i.code == srg_status_pkg::SRG_CMD_ALM_ENW),
            cmd_i.data, clr_en);
        opr_d = grp_next(opr_q, opr_state_i,
            cls || (cmd_i.valid
                    && (cmd_i.code == srg_status_pkg::SRG_CMD_OPR_EVT)),
            cmd_i.valid && (cmd_i.code == srg_status_pkg::SRG_CMD_OPR_ENW),
            cmd_i.data, clr_en);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alm_q <= srg_status_pkg::GRP_RST;
            opr_q <= srg_status_pkg::GRP_RST;
        end else begin
            alm_q <= alm_d;
            opr_q <= opr_d;
        end
    end

    // Query answers carry the value held before this cycle's update, so an
    // event read reports the bits it is about to clear.
    // condition read has no side effect
    always_comb begin
        resp_d.valid = 1'b0;
        resp_d.data = srg_status_pkg::DATA_RST;
        if (cmd_i.valid) begin
            resp_d.valid = 1'b1;
            case (cmd_i.code)
                srg_status_pkg::SRG_CMD_ALM_COND: resp_d.data = alm_q.cond;
                srg_status_pkg::SRG_CMD_ALM_EVT: resp_d.data = alm_q.evt;
                srg_status_pkg::SRG_CMD_ALM_ENQ: resp_d.data = alm_q.en;
                srg_status_pkg::SRG_CMD_OPR_COND: resp_d.data = opr_q.cond;
                srg_status_pkg::SRG_CMD_OPR_EVT: resp_d.data = opr_q.evt;
                srg_status_pkg::SRG_CMD_OPR_ENQ: resp_d.data = opr_q.en;
                default: resp_d.valid = 1'b0;
            endcase
        end
    end

    // Summaries are registered so the outputs come from flip-flops; they
    // trail the event and enable registers by one cycle.
    // enable masks events
    always_comb begin
        alm_sum_d = summary_of(alm_q);
        opr_sum_d = summary_of(opr_q);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            resp_q <= '{valid: 1'b0, data: srg_status_pkg::DATA_RST};
            alm_sum_q <= 1'b0;
            opr_sum_q <= 1'b0;
        end else begin
            resp_q <= resp_d;
            alm_sum_q <= alm_sum_d;
            opr_sum_q <= opr_sum_d;
        end
    end

    assign resp_o = resp_q;
    assign alm_summary_o = alm_sum_q;
    assign opr_summary_o = opr_sum_q;

    // Checks on the group behaviour. They rest while reset is low, since
    // every register is then held at zero whatever the inputs do.
    // condition follows state
    chk_cond_follow: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ##1 ((alm_q.cond == $past(alm_state_i))
             && (opr_q.cond == $past(opr_state_i))))
        else $error("Condition did not follow state.");

    chk_cond_query: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_ALM_COND)
        |=> resp_o.valid && (resp_o.data == $past(alm_q.cond))
        && (alm_q.evt == ($past(alm_q.evt) | $past(alm_rise))))
        else $error("Condition query wrong or had side effect.");

    chk_opr_query: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_OPR_COND)
        |=> resp_o.valid && (resp_o.data == $past(opr_q.cond)))
        else $error("Operation condition query wrong.");

    chk_evt_capture: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (alm_rise != 15'h0000)
        |=> ((alm_q.evt & $past(alm_rise)) == $past(alm_rise)))
        else $error("Rising condition not captured.");

    chk_opr_capture: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (opr_rise != 15'h0000)
        |=> ((opr_q.evt & $past(opr_rise)) == $past(opr_rise)))
        else $error("Rising operation condition not captured.");

    chk_evt_source: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ##1 ((opr_q.evt & ~$past(opr_q.evt) & ~$past(opr_rise))
             == 15'h0000))
        else $error("Event bit set without occurrence.");

    chk_alm_source: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ##1 ((alm_q.evt & ~$past(alm_q.evt) & ~$past(alm_rise))
             == 15'h0000))
        else $error("Alarm event bit set without occurrence.");

    chk_evt_hold: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !(cmd_i.valid && (cmd_i.code == srg_status_pkg::SRG_CMD_ALM_EVT
                          || cmd_i.code == srg_status_pkg::SRG_CMD_CLS))
        |=> ((alm_q.evt & $past(alm_q.evt)) == $past(alm_q.evt)))
        else $error("Set event bit lost without clear.");

    chk_evt_clear: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_CLS)
        |=> (alm_q.evt == $past(alm_rise))
        && (opr_q.evt == $past(opr_rise)))
        else $error("Clear status did not clear events.");

    chk_alm_read_clear: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_ALM_EVT)
        |=> resp_o.valid && (resp_o.data == $past(alm_q.evt))
        && (alm_q.evt == $past(alm_rise))
        && (opr_q.evt == ($past(opr_q.evt) | $past(opr_rise))))
        else $error("Alarm event read did not clear only its group.");

    chk_opr_read_clear: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_OPR_EVT)
        |=> resp_o.valid && (resp_o.data == $past(opr_q.evt))
        && (opr_q.evt == $past(opr_rise))
        && (alm_q.evt == ($past(alm_q.evt) | $past(alm_rise))))
        else $error("Operation event read did not clear only its group.");

    chk_summary_mask: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ##1 ((alm_summary_o == $past(|(alm_q.evt & alm_q.en)))
             && (opr_summary_o == $past(|(opr_q.evt & opr_q.en)))))
        else $error("Summary does not match masked events.");

    chk_mask_silent: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (alm_q.en == 15'h0000) |=> !alm_summary_o)
        else $error("Alarm summary raised with every bit masked.");

    chk_en_write: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_ALM_ENW
         && !(pwr_on_i && psc_i))
        |=> (alm_q.en == $past(cmd_i.data))
        && $stable(opr_q.en))
        else $error("Enable write not stored in its own group.");

    chk_alm_en_query: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_ALM_ENQ)
        |=> resp_o.valid && (resp_o.data == $past(alm_q.en)))
        else $error("Alarm enable query wrong.");

    chk_en_readback: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_OPR_ENQ)
        |=> resp_o.valid && (resp_o.data == $past(opr_q.en)))
        else $error("Operation enable query wrong.");

    chk_opr_en_write: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_OPR_ENW
         && !(pwr_on_i && psc_i))
        |=> (opr_q.en == $past(cmd_i.data))
        && $stable(alm_q.en))
        else $error("Operation enable write not kept in its group.");

    chk_preset_clear: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cmd_i.valid && cmd_i.code == srg_status_pkg::SRG_CMD_PRESET)
        |=> (alm_q.en == 15'h0000) && (opr_q.en == 15'h0000)
        && (opr_q.evt == ($past(opr_q.evt) | $past(opr_rise))))
        else $error("Preset did not clear only the enables.");

    chk_psc_keep: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (pwr_on_i && !psc_i && !cmd_i.valid)
        |=> $stable(alm_q.en) && $stable(opr_q.en))
        else $error("Enables changed at power up with clear off.");

    chk_psc_clear: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (pwr_on_i && psc_i)
        |=> (alm_q.en == 15'h0000) && (opr_q.en == 15'h0000))
        else $error("Enables kept at power up with clear on.");

endmodule // srg_status_top

`default_nettype wire

// *** dv/srg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Remote host that issues one status command per clock when asked.
module srg_host_model (
    // Clock.
    input wire logic clk_i,
    // Command towards the device.
    output var srg_status_pkg::srg_cmd_t cmd_o
);
    initial cmd_o = '0;

    // enable value range
    // A fifteen bit field keeps every written value within 0 to 32767.
    task automatic send(input logic [3:0] code, input logic [14:0] data);
        cmd_o <= '{valid: 1'b1, code: srg_status_pkg::srg_cmd_e_t'(code),
                   data: data};
        @(posedge clk_i);
    endtask

    // Idle cycles scramble code and data, so a stale field is never used.
    task automatic idle();
        cmd_o <= '{valid: 1'b0,
                   code: srg_status_pkg::srg_cmd_e_t'(4'($urandom)),
                   data: ~cmd_o.data};
        @(posedge clk_i);
    endtask
endmodule // srg_host_model

`default_nettype wire

// *** dv/status_register_groups_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module status_register_groups_tb;
    localparam logic [3:0] DC [18] = '{4'h3, 4'h4, 4'h3, 4'h8, 4'h7, 4'h1,
        4'h1, 4'h2, 4'h2, 4'h6, 4'h5, 4'hA, 4'h3, 4'h7, 4'h9, 4'h2, 4'h4, 4'h8};
    localparam logic [14:0] DA [18] = '{15'h0000, 15'h7FFF, 15'h7FFF,
        15'h0001, 15'h0001, 15'h0005, 15'h0005, 15'h0007, 15'h0007, 15'h0000,
        15'h0000, 15'h0000, 15'h0000, 15'h0000, 15'h0003, 15'h0003, 15'h7FFF,
        15'h7FFF};
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [14:0] alm_st = 15'h0000;
    logic [14:0] opr_st = 15'h0000;
    logic pwr_on = 1'b0;
    logic psc = 1'b0;
    srg_status_pkg::srg_cmd_t cmd;
    srg_status_pkg::srg_resp_t resp;
    logic alm_sum;
    logic opr_sum;
    int n_mismatch = 0;
    int checked = 0;
    logic [14:0] m_cond [2];
    logic [14:0] m_evt [2];
    logic [14:0] m_en [2];
    logic [14:0] m_rd;
    logic m_rv;
    logic [1:0] m_sum;
    logic [14:0] st [2];
    logic [3:0] c;

    // Half period of 2.5 ns gives the 200 MHz clock.
    always #2.5 clk_i = ~clk_i;

    // Per-group state view and the command that the device takes.
    assign st[0] = alm_st;
    assign st[1] = opr_st;
    assign c = cmd.valid ? cmd.code : 4'h0;

    srg_host_model u_srg_host_model (.clk_i(clk_i), .cmd_o(cmd));

    srg_status_top u_srg_status_top (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .alm_state_i(alm_st),
        .opr_state_i(opr_st), .pwr_on_i(pwr_on), .psc_i(psc), .cmd_i(cmd),
        .resp_o(resp), .alm_summary_o(alm_sum), .opr_summary_o(opr_sum));

    // Next event word: a clear drops old bits, but a rising edge wins.
    function automatic logic [14:0] evt_next(input logic [14:0] e, q, s,
                                             input logic clr);
        return (clr ? 15'h0000 : e) | (s & ~q);
    endfunction

    // Reference model; group g uses codes 4g+1 to 4g+4.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            m_cond <= '{15'h0000, 15'h0000};
            m_evt <= '{15'h0000, 15'h0000};
            m_en <= '{15'h0000, 15'h0000};
            m_rv <= 1'b0;
            m_sum <= 2'b00;
        end else begin
            m_rv <= c inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
            for (int g = 0; g < 2; g++) begin
                if (c == 4'(4 * g + 1)) m_rd <= m_cond[g];
                if (c == 4'(4 * g + 2)) m_rd <= m_evt[g];
                if (c == 4'(4 * g + 3)) m_rd <= m_en[g];
                m_cond[g] <= st[g];
                m_evt[g] <= evt_next(m_evt[g], m_cond[g], st[g],
                                     c == 4'(4 * g + 2) || c == 4'h9);
                if (c == 4'hA || (pwr_on && psc)) m_en[g] <= 15'h0000;
                else if (c == 4'(4 * g + 4)) m_en[g] <= cmd.data;
                m_sum[g] <= |(m_evt[g] & m_en[g]);
            end
        end
    end

    task automatic check(input string name, input logic [14:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Outputs have settled by the falling edge, reset included.
    always @(negedge clk_i) begin
        check("resp valid", 15'(resp.valid), 15'(m_rv));
        if (m_rv === 1'b1) begin
            check("resp data", resp.data, m_rd);
        end
        check("alarm summary", 15'(alm_sum), 15'(m_sum[0]));
        check("oper summary", 15'(opr_sum), 15'(m_sum[1]));
    end

    // One clock of stimulus; code zero leaves the command port idle.
    task automatic step(input logic [3:0] code, input logic [14:0] d, a, o,
                        input logic p, s);
        alm_st <= a;
        opr_st <= o;
        pwr_on <= p;
        psc <= s;
        if (code == 4'h0) begin
            u_srg_host_model.idle();
        end else begin
            u_srg_host_model.send(code, d);
        end
    endtask

    // Sparse state bits keep some events from being set every cycle.
    task automatic rnd(input int n);
        repeat (n) step(4'($urandom), 15'($urandom), 15'($urandom & $urandom),
                        15'($urandom & $urandom), $urandom % 32 == 0,
                        1'($urandom));
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(21747));
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        // boundary writes, preset, set beats clear
        foreach (DC[i]) step(DC[i], DA[i], DA[i], ~DA[i], 1'b0, 1'b0);
        // power-on keeps, then clears, the enable masks
        step(4'h0, 15'h0000, 15'h0000, 15'h0000, 1'b1, 1'b0);
        step(4'h7, 15'h0000, 15'h0000, 15'h0000, 1'b0, 1'b0);
        step(4'h0, 15'h0000, 15'h0000, 15'h0000, 1'b1, 1'b1);
        step(4'h3, 15'h0000, 15'h0000, 15'h0000, 1'b0, 1'b0);
        rnd(3000);
        // A second reset in mid-run must bring every register back to zero.
        // Inputs rest at zero over the release edge: that edge still finds
        // the flops in reset, so a command or rise sampled there is lost.
        arst_n_i <= 1'b0;
        repeat (3) step(4'h0, 15'h0000, 15'h0000, 15'h0000, 1'b0, 1'b0);
        arst_n_i <= 1'b1;
        // enable masks read back as zero after reset
        step(4'h3, 15'h0000, 15'h0000, 15'h0000, 1'b0, 1'b0);
        step(4'h7, 15'h0000, 15'h0000, 15'h0000, 1'b0, 1'b0);
        rnd(300);
        end_of_test();
    end
endmodule // status_register_groups_tb

`default_nettype wire
